/* prv_pkg.sv */
// How it works
// - A supervisor mode bit of 1 means supervisor mode, with every resource but translated alternate space loads and stores open to the program.
// - A supervisor mode bit of 0 means user mode, and exactly one of the two modes holds.
// - The privilege level output is high in supervisor mode and low in user mode, one cycle behind the mode bit.
// - Any user-mode access to a translation look-aside buffer entry raises a violation.
// - A user-mode access to a register whose bank protect bit is 1 raises a violation.
// - A user-mode load or store with its physical or user access option bit set raises one.
// - A translated load or store with the alternate space bit set raises one in either mode.
// - User-mode interrupt return, return and invalidate, invalidate or halt raises one.
// - A development system may switch off the halt check so halt can act as a breakpoint.
// - User-mode access to any of the fifteen protected special registers raises one.
// - A user-mode assert or emulate naming vector 0 through 63 raises one.
// - The bank protect register has sixteen bits, bit n guarding bank n, bank 0 being 2 to 15.
// - Bank checks use absolute numbers, so local numbers get the stack pointer added first.
// - In supervisor mode the bank protect register plays no part in register checks.
`default_nettype none

package prv_pkg;

   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned CAUSE_W   = 7;
   localparam int unsigned NUM_PORTS = 3;

   // Register byte offsets
   localparam logic [7:0] OFF_BANK_PROT  = 8'h00;
   localparam logic [7:0] OFF_INT_STATUS = 8'h04;
   localparam logic [7:0] OFF_INT_MASK   = 8'h08;
   localparam logic [7:0] OFF_STATE      = 8'h0C;

   // Reset values
   localparam logic [15:0]        BANK_PROT_RST = 16'h0000;
   localparam logic [CAUSE_W-1:0] INT_MASK_RST  = 7'h00;
   localparam logic [CAUSE_W-1:0] CAUSE_RST     = 7'h00;

   // Cause bit positions, shared by status, mask and last cause
   localparam int unsigned C_TLB  = 0;
   localparam int unsigned C_BANK = 1;
   localparam int unsigned C_LSOP = 2;
   localparam int unsigned C_ALTS = 3;
   localparam int unsigned C_PRIV = 4;
   localparam int unsigned C_SPR  = 5;
   localparam int unsigned C_VEC  = 6;

   // State register field positions
   localparam int unsigned ST_MODE_POS = 8;
   localparam int unsigned ST_HALT_POS = 9;

   // Register numbering
   localparam int unsigned LOCAL_BIT         = 7;
   localparam logic [7:0]  GPR_FIRST_BANKED  = 8'h02;
   localparam logic [7:0]  SPR_PROT_COUNT    = 8'h0F;
   localparam logic [7:0]  VEC_PROT_LAST     = 8'h3F;

endpackage

`default_nettype wire

/* prv_bank_if.sv */
`default_nettype none

interface prv_bank_if;
   logic [7:0]  reg_num;
   logic        used;
   logic [6:0]  sp_base;
   logic [15:0] bank_prot;
   logic        user_mode;
   logic        hit;

   modport checker_side (
      input  reg_num,
      input  used,
      input  sp_base,
      input  bank_prot,
      input  user_mode,
      output hit
   );

   modport source_side (
      output reg_num,
      output used,
      output sp_base,
      output bank_prot,
      output user_mode,
      input  hit
   );
endinterface

`default_nettype wire

/* prv_bank_check.sv */
`default_nettype none

module prv_bank_check
   import prv_pkg::*;
(
   prv_bank_if.checker_side bank_io
);

   logic [7:0] abs_num;
   logic [6:0] local_sum;

   // Local numbers wrap within seven bits, the top bit stays set
   assign local_sum = bank_io.reg_num[6:0] + bank_io.sp_base;

   assign abs_num = bank_io.reg_num[LOCAL_BIT] ? {1'b1, local_sum}
                                               : bank_io.reg_num;

   // Global 0 and 1 sit outside every bank
   assign bank_io.hit = bank_io.used
                        && bank_io.user_mode
                        && (abs_num >= GPR_FIRST_BANKED)
                        && bank_io.bank_prot[abs_num[7:4]];

endmodule

`default_nettype wire

/* prv_protection_check.sv */
`default_nettype none

module prv_protection_check
   import prv_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 reset_n_in,

   // APB slave
   input  wire logic                 psel_in,
   input  wire logic                 penable_in,
   input  wire logic                 pwrite_in,
   input  wire logic [ADDR_W-1:0]    paddr_in,
   input  wire logic [31:0]          pwdata_in,
   output logic      [31:0]          prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,

   // Mode and channel
   input  wire logic                 supervisor_mode_bit_in,
   output logic                      privilege_level_output_out,

   // Development system pin
   input  wire logic                 halt_check_disable_in,

   // Decode and execute request
   input  wire logic                 check_valid_in,
   input  wire logic                 tlb_access_in,
   input  wire logic [NUM_PORTS-1:0] gpr_used_in,
   input  wire logic [NUM_PORTS-1:0][7:0] gpr_num_in,
   input  wire logic [6:0]           stack_ptr_base_in,
   input  wire logic                 load_store_in,
   input  wire logic                 translated_in,
   input  wire logic                 physical_access_option_bit_in,
   input  wire logic                 user_access_option_bit_in,
   input  wire logic                 alternate_space_option_bit_in,
   input  wire logic                 irq_return_in,
   input  wire logic                 irq_return_inval_in,
   input  wire logic                 invalidate_in,
   input  wire logic                 halt_in,
   input  wire logic                 spr_access_in,
   input  wire logic [7:0]           spr_num_in,
   input  wire logic                 vector_trap_in,
   input  wire logic [7:0]           vector_num_in,

   // Results
   output logic                      suppress_out,
   output logic                      trap_out,
   output logic      [CAUSE_W-1:0]   trap_cause_out,
   output logic                      irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [15:0]        bank_prot;
      logic [CAUSE_W-1:0] int_mask;
      logic [CAUSE_W-1:0] int_status;
      logic [CAUSE_W-1:0] last_cause;
      logic [31:0]        rdata;
      logic               slverr;
      logic               trap;
      logic               priv;
      logic               halt_s1;
      logic               halt_s2;
   } prv_state_t;

   prv_state_t s;
   prv_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////
   // Bank checks, one per operand and result port

   logic                 user_mode;
   logic [NUM_PORTS-1:0] bank_hit;

   assign user_mode = ~supervisor_mode_bit_in;

   prv_bank_if bank_bus [NUM_PORTS] ();

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         assign bank_bus[gi].reg_num   = gpr_num_in[gi];
         assign bank_bus[gi].used      = gpr_used_in[gi];
         assign bank_bus[gi].sp_base   = stack_ptr_base_in;
         assign bank_bus[gi].bank_prot = s.bank_prot;
         assign bank_bus[gi].user_mode = user_mode;
         assign bank_hit[gi]           = bank_bus[gi].hit;

         prv_bank_check u_check (
            .bank_io (bank_bus[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Cause evaluation

   logic [CAUSE_W-1:0] cause;
   logic               halt_checked;
   logic               priv_instr;
   logic               violation;

   // Sync output only; a disable that changes mid-instruction may miss one
   assign halt_checked = halt_in & ~s.halt_s2;

   assign priv_instr = irq_return_in
                       | irq_return_inval_in
                       | invalidate_in
                       | halt_checked;

   always_comb begin
      cause = '0;
      if (check_valid_in) begin
         cause[C_TLB]  = user_mode & tlb_access_in;
         cause[C_BANK] = |bank_hit;
         cause[C_LSOP] = user_mode & load_store_in
                         & (physical_access_option_bit_in
                            | user_access_option_bit_in);
         // No mode gate: checked in supervisor mode as well
         cause[C_ALTS] = load_store_in & translated_in
                         & alternate_space_option_bit_in;
         cause[C_PRIV] = user_mode & priv_instr;
         cause[C_SPR]  = user_mode & spr_access_in
                         & (spr_num_in < SPR_PROT_COUNT);
         cause[C_VEC]  = user_mode & vector_trap_in
                         & (vector_num_in <= VEC_PROT_LAST);
      end
   end

   assign violation = |cause;

   // Combinational so the pipeline can cancel write-back this cycle
   assign suppress_out = violation;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic              apb_setup;
   logic              apb_access;
   logic              addr_hit;
   logic [31:0]       read_val;
   logic              status_clear;

   assign apb_setup  = psel_in & ~penable_in;
   assign apb_access = psel_in & penable_in;

   always_comb begin
      addr_hit = 1'b1;
      read_val = 32'h0000_0000;
      if (paddr_in == OFF_BANK_PROT) begin
         read_val[15:0] = s.bank_prot;
      end else if (paddr_in == OFF_INT_STATUS) begin
         read_val[CAUSE_W-1:0] = s.int_status;
      end else if (paddr_in == OFF_INT_MASK) begin
         read_val[CAUSE_W-1:0] = s.int_mask;
      end else if (paddr_in == OFF_STATE) begin
         read_val[CAUSE_W-1:0] = s.last_cause;
         read_val[ST_MODE_POS] = supervisor_mode_bit_in;
         read_val[ST_HALT_POS] = s.halt_s2;
      end else begin
         addr_hit = 1'b0;
      end
   end

   assign status_clear = apb_access & ~pwrite_in
                         & (paddr_in == OFF_INT_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_s = s;

      next_s.halt_s1 = halt_check_disable_in;
      next_s.halt_s2 = s.halt_s1;

      // Mode is presented to the channel one cycle behind the status bit
      next_s.priv = supervisor_mode_bit_in;

      // Read data and error are latched in setup, shown in access
      if (apb_setup) begin
         next_s.rdata  = pwrite_in ? 32'h0000_0000 : read_val;
         next_s.slverr = ~addr_hit;
      end

      if (apb_access & pwrite_in) begin
         if (paddr_in == OFF_BANK_PROT) begin
            next_s.bank_prot = pwdata_in[15:0];
         end else if (paddr_in == OFF_INT_MASK) begin
            next_s.int_mask = pwdata_in[CAUSE_W-1:0];
         end
      end

      // Trap reported as one pulse with its cause
      next_s.trap = violation;
      if (violation) begin
         next_s.last_cause = cause;
      end

      // Clear only the bits handed out at setup, so a setup-cycle event survives
      // New events win over a read-clear in the same cycle
      next_s.int_status = (s.int_status & ~(status_clear ? s.rdata[CAUSE_W-1:0] : CAUSE_RST))
                          | cause;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s.bank_prot  <= BANK_PROT_RST;
         s.int_mask   <= INT_MASK_RST;
         s.int_status <= CAUSE_RST;
         s.last_cause <= CAUSE_RST;
         s.rdata      <= 32'h0000_0000;
         s.slverr     <= 1'b0;
         s.trap       <= 1'b0;
         s.priv       <= 1'b0;
         s.halt_s1    <= 1'b0;
         s.halt_s2    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata_out                 = s.rdata;
   assign pready_out                 = apb_access;
   assign pslverr_out                = apb_access & s.slverr;
   assign privilege_level_output_out = s.priv;
   assign trap_out                   = s.trap;
   assign trap_cause_out             = s.last_cause;
   assign irq_out                    = |(s.int_status & s.int_mask);

endmodule

`default_nettype wire

/* prv_prot_checker.sv */
`default_nettype none
module prv_prot_checker
   import prv_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   input wire logic       supervisor_mode_bit_in,
   input wire logic       privilege_level_output_out,
   input wire logic       check_valid_in,
   input wire logic       tlb_access_in,
   input wire logic       load_store_in,
   input wire logic       translated_in,
   input wire logic       physical_access_option_bit_in,
   input wire logic       user_access_option_bit_in,
   input wire logic       alternate_space_option_bit_in,
   input wire logic       irq_return_in,
   input wire logic       irq_return_inval_in,
   input wire logic       invalidate_in,
   input wire logic       spr_access_in,
   input wire logic [7:0] spr_num_in,
   input wire logic       vector_trap_in,
   input wire logic [7:0] vector_num_in,
   input wire logic       suppress_out,
   input wire logic       trap_out,
   input wire logic [6:0] trap_cause_out,
   input wire logic       irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic uv;
   logic ast;
   assign uv = check_valid_in && !supervisor_mode_bit_in;
   assign ast = check_valid_in && load_store_in && translated_in && alternate_space_option_bit_in;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   a_level_lags_mode: assert property ($past(reset_n_in) |->
      privilege_level_output_out == $past(supervisor_mode_bit_in)) else $error("level lag");
   a_trap_after_fail: assert property ($past(reset_n_in) |->
      trap_out == $past(check_valid_in && suppress_out)) else $error("trap pulse");
   a_tlb_user_trap: assert property (uv && tlb_access_in |->
      suppress_out ##1 trap_out && trap_cause_out[C_TLB]) else $error("tlb");
   a_option_user_trap: assert property (uv && load_store_in &&
      (physical_access_option_bit_in || user_access_option_bit_in) |=> trap_cause_out[C_LSOP])
      else $error("option bits");
   a_alt_any_mode: assert property (ast |-> suppress_out ##1 trap_cause_out[C_ALTS])
      else $error("alt space");
   a_super_only_alt: assert property (check_valid_in && supervisor_mode_bit_in && !ast
      |-> !suppress_out) else $error("supervisor trap");
   a_priv_instr_trap: assert property (uv && (irq_return_in || irq_return_inval_in
      || invalidate_in) |=> trap_cause_out[C_PRIV]) else $error("priv instr");
   a_spr_user_trap: assert property (uv && spr_access_in && spr_num_in < SPR_PROT_COUNT
      |=> trap_cause_out[C_SPR]) else $error("special reg");
   a_vec_low_trap: assert property (uv && vector_trap_in && vector_num_in <= VEC_PROT_LAST
      |=> trap_cause_out[C_VEC]) else $error("vector");
   cover property (trap_out && trap_cause_out[C_BANK]);
   cover property (irq_out);
   cover property (ast && supervisor_mode_bit_in);
endmodule
bind prv_protection_check prv_prot_checker chk (.*);
`default_nettype wire

/* prv_pipe_model.sv */
`default_nettype none
module prv_pipe_model (
   input  wire logic        clk_in,
   input  wire logic        issue_in,
   input  wire logic [61:0] cmd_in,
   output logic      [62:0] req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [62:0] held = '0;
   // Idle clears valid and inverts the other fields, so a stale request never looks valid
   always @(posedge clk_in)
      held <= issue_in ? {1'b1, cmd_in} : {1'b0, ~cmd_in};
   assign req_out = held;
endmodule
`default_nettype wire

/* tb.sv */
`default_nettype none
module tb
   import prv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic pready_out, pslverr_out, privilege_level_output_out, suppress_out, trap_out, irq_out;
   logic supervisor_mode_bit_in = 0, halt_check_disable_in = 0, issue_in = 0, ev;
   logic check_valid_in, tlb_access_in, load_store_in, translated_in, halt_in;
   logic physical_access_option_bit_in, user_access_option_bit_in, spr_access_in;
   logic alternate_space_option_bit_in, irq_return_in, irq_return_inval_in;
   logic invalidate_in, vector_trap_in;
   logic [2:0] gpr_used_in;
   logic [2:0][7:0] gpr_num_in;
   logic [6:0] stack_ptr_base_in, trap_cause_out;
   logic [7:0] paddr_in = '0, spr_num_in, vector_num_in;
   logic [31:0] pwdata_in = '0, prdata_out, rv;
   logic [61:0] cmd_in = '0, c;
   logic [62:0] req_out;
   logic [15:0] bp = '0;
   logic [11:0] f;
   logic [61:0] dl [12] = '{62'h13F, 62'h140, 62'h21C00, 62'h21E00, 62'h5000000, 62'h4800000,
      62'h6400000, 62'h4400000, 62'h0400000800000000, 62'h0400000400000000,
      62'h040003FC08000000, 62'h04000203F8000000};
   int fails = 0, cmp_count = 0, cyc = 0;
   assign {check_valid_in, tlb_access_in, gpr_used_in, gpr_num_in, stack_ptr_base_in,
      load_store_in, translated_in, physical_access_option_bit_in, user_access_option_bit_in,
      alternate_space_option_bit_in, irq_return_in, irq_return_inval_in, invalidate_in,
      halt_in, spr_access_in, spr_num_in, vector_trap_in, vector_num_in} = req_out;
   prv_protection_check dut (.*);
   prv_pipe_model pm (.*);
   always #20 clk_in = ~clk_in;
   ////////////////////////////////////////
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1;
      // Ends on pready_out; only the bench timeout guards this wait
      do
         @(posedge clk_in);
      while (pready_out !== 1'b1);
      rv = prdata_out;
      ev = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] w);
      apb(0, a, '0);
      chk(rv, w);
   endtask
   task automatic wbp(input logic [15:0] v);
      bp = v;
      apb(1, OFF_BANK_PROT, 32'(v));
   endtask
   // Expected cause vector; supervisor keeps only the alternate space check
   function automatic logic [6:0] exp_cause(input logic [61:0] v, input logic m);
      logic [6:0] e;
      logic [7:0] a;
      e = '0;
      for (int i = 0; i < 3; i++) begin
         a = v[34+8*i +: 8];
         if (a[7])
            a[6:0] = a[6:0] + v[33:27];
         if (v[58+i] && a > 8'h01 && bp[a[7:4]])
            e[C_BANK] = 1;
      end
      e[C_TLB] = v[61];
      e[C_LSOP] = v[26] & (v[24] | v[23]);
      e[C_PRIV] = v[21] | v[20] | v[19] | (v[18] & !halt_check_disable_in);
      e[C_SPR] = v[17] && v[16:9] < SPR_PROT_COUNT;
      e[C_VEC] = v[8] && v[7:0] <= VEC_PROT_LAST;
      if (m)
         e = '0;
      e[C_ALTS] = v[26] & v[25] & v[22];
      return e;
   endfunction
   task automatic req(input logic [61:0] v, input logic m);
      logic [6:0] e;
      @(posedge clk_in);
      e = exp_cause(v, m);
      issue_in <= 1;
      cmd_in <= v;
      supervisor_mode_bit_in <= m;
      @(posedge clk_in);
      issue_in <= 0;
      #1 chk(32'(suppress_out), 32'(|e));
      @(posedge clk_in);
      #1 chk(32'(trap_out), 32'(|e));
      if (|e)
         chk(32'(trap_cause_out), 32'(e));
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   ////////////////////////////////////////
   initial begin
      void'($urandom(75));
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1;
      rd(OFF_BANK_PROT, 32'(BANK_PROT_RST));
      rd(OFF_INT_STATUS, 0);
      rd(OFF_INT_MASK, 32'(INT_MASK_RST));
      rd(OFF_STATE, 0);
      wbp(16'hFFFF);
      rd(OFF_BANK_PROT, 32'h0000FFFF);
      apb(0, 8'h10, '0);
      chk(32'(ev), 1);
      chk(rv, 0);
      $display("test registers done");
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_in);
         supervisor_mode_bit_in <= (i % 3 != 0);
         @(posedge clk_in);
         #1 chk(32'(privilege_level_output_out), 32'(i % 3 != 0));
      end
      $display("test level done");
      wbp(16'h0101);
      for (int m = 0; m < 2; m++) begin
         foreach (dl[k])
            req(dl[k], 1'(m));
         for (int k = 0; k < 62; k++)
            req(62'(1) << k, 1'(m));
      end
      for (int h = 1; h >= 0; h--) begin
         halt_check_disable_in <= 1'(h);
         repeat (3) @(posedge clk_in);
         req(62'h40000, 0);
      end
      $display("test corners done");
      for (int i = 0; i < 300; i++) begin
         if (i % 30 == 0) begin
            wbp(16'($urandom & $urandom));
            halt_check_disable_in <= 1'($urandom);
            repeat (3) @(posedge clk_in);
         end
         f = 12'($urandom & $urandom & $urandom);
         c = 62'({$urandom, $urandom});
         c[61] = f[0];
         c[26:17] = f[10:1];
         c[8] = f[11];
         req(c, 1'($urandom));
      end
      $display("test random done");
      apb(0, OFF_INT_STATUS, '0);
      apb(1, OFF_INT_MASK, '0);
      req(62'h2000000000000000, 0);
      chk(32'(irq_out), 0);
      rd(OFF_INT_STATUS, 32'h1);
      rd(OFF_INT_STATUS, 0);
      apb(1, OFF_INT_MASK, 32'hFFFFFFFF);
      rd(OFF_INT_MASK, 32'h7F);
      req(62'h2000000000000000, 0);
      chk(32'(irq_out), 1);
      apb(0, OFF_INT_STATUS, '0);
      #1 chk(32'(irq_out), 0);
      $display("test interrupt done");
      close_out();
   end
endmodule
`default_nettype wire
